// ### rtl/lte_pkg.sv
// constants for the low power timer encoder interface
package lte_pkg;
  localparam int ADDR_W = 5;
  localparam logic [4:0] OFS_STS = 5'h00;
  localparam logic [4:0] OFS_CLR = 5'h04;
  localparam logic [4:0] OFS_IEN = 5'h08;
  localparam logic [4:0] OFS_CFG = 5'h0C;
  localparam logic [4:0] OFS_CTRL = 5'h10;
  localparam logic [4:0] OFS_CMP = 5'h14;
  localparam logic [4:0] OFS_ARR = 5'h18;
  localparam logic [4:0] OFS_CNT = 5'h1C;
  // status, clear and enable bit positions
  localparam int NFLG = 7;
  localparam int FLG_CMPM = 0;
  localparam int FLG_ARRM = 1;
  localparam int FLG_EXTERNAL_TRIGGER_FLAG = 2;
  localparam int FLG_CMPUPD = 3;
  localparam int FLG_RELOAD_WRITE_DONE_FLAG = 4;
  localparam int FLG_UP = 5;
  localparam int FLG_DOWN = 6;
  // configuration bit positions
  localparam int CFG_CLOCK_SOURCE_SELECT = 0;
  localparam int CFG_POL_LO = 1;
  localparam int CFG_PRE_LO = 9;
  localparam int CFG_TRG_LO = 17;
  localparam int CFG_TMO = 19;
  localparam int CFG_ENC = 23;
  localparam int CFG_PULSE_DIRECTION_DECODER_ENABLE = 24;
  localparam logic [31:0] CFG_MASK = 32'h018E_0E07;
  // control bit positions
  localparam int CTRL_EN = 0;
  localparam int CTRL_SNG = 1;
  localparam int CTRL_CONT = 2;
  // reset values
  localparam logic [15:0] ARR_RST = 16'h0001;
  localparam logic [15:0] CMP_RST = 16'h0000;
  localparam logic [15:0] CNT_RST = 16'h0000;
  localparam logic [31:0] CFG_RST = 32'h0000_0000;
  localparam logic [2:0] CTRL_RST = 3'h0;
  // edge polarity codes
  localparam logic [1:0] POL_RISE = 2'h0;
  localparam logic [1:0] POL_FALL = 2'h1;
  localparam logic [1:0] POL_BOTH = 2'h2;
  // trigger source codes
  localparam logic [1:0] TRG_SW = 2'h0;
  localparam logic [1:0] TRG_RISE = 2'h1;
  localparam logic [1:0] TRG_FALL = 2'h2;
  // pin indices in the synchroniser
  localparam int NPIN = 3;
  localparam int PIN_IN1 = 0;
  localparam int PIN_IN2 = 1;
  localparam int PIN_TRG = 2;
  typedef enum logic [1:0] {LTE_IDLE, LTE_WAIT, LTE_RUN} lte_run_e;
endpackage

// ### rtl/lte_pin_if.sv
// filtered pin levels and edges between synchroniser and timer
`timescale 1ns/1ns
interface lte_pin_if #(parameter int N = 3);
  logic [N-1:0] lvl;
  logic [N-1:0] rise;
  logic [N-1:0] fall;
  modport src (output lvl, output rise, output fall);
  modport dst (input lvl, input rise, input fall);
endinterface // lte_pin_if

// ### rtl/lte_pin_sync.sv
// three-stage pin synchroniser with agreement filter and edge detect
`timescale 1ns/1ns
module lte_pin_sync import lte_pkg::*; #(
  parameter int N = 3
) (
  // clock, reset, enable
  input wire logic core_clk_in,
  input wire logic nrst_in,
  input wire logic ce_in,
  // pins and filtered view
  input wire logic [N-1:0] pin_in,
  lte_pin_if.src pins
);
  logic [N-1:0] s1_q;
  logic [N-1:0] s2_q;
  logic [N-1:0] s3_q;
  logic [N-1:0] filt_q;
  logic [N-1:0] prev_q;
  wire logic [N-1:0] filt_d;

  // level only moves once stages two and three agree
  assign filt_d = (s2_q & s3_q) | (filt_q & (s2_q | s3_q));

  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
      filt_q <= '0;
      prev_q <= '0;
    end else if (ce_in) begin
      s1_q <= pin_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
      filt_q <= filt_d;
      prev_q <= filt_q;
    end
  end

  assign pins.lvl = filt_q;
  assign pins.rise = filt_q & ~prev_q;
  assign pins.fall = ~filt_q & prev_q;
endmodule // lte_pin_sync

// ### rtl/lte_timer.sv
// low power timer with quadrature, pulse-direction decoders and timeout
`timescale 1ns/1ns
module lte_timer import lte_pkg::*; (
  // clock, reset, enable
  input wire logic core_clk_in,
  input wire logic nrst_in,
  input wire logic ce_in,
  // register port
  input wire logic [ADDR_W-1:0] addr_in,
  input wire logic [31:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [31:0] rdata_out,
  // encoder and trigger pins
  input wire logic enc_a_in,
  input wire logic enc_b_in,
  input wire logic trig_in,
  // status
  output logic irq_out,
  output logic dir_up_out
);
  lte_pin_if #(.N(NPIN)) pins ();

  lte_pin_sync #(.N(NPIN)) u_sync (
    .core_clk_in(core_clk_in),
    .nrst_in(nrst_in),
    .ce_in(ce_in),
    .pin_in({trig_in, enc_b_in, enc_a_in}),
    .pins(pins)
  );

  logic [NFLG-1:0] sts_q;
  logic [NFLG-1:0] ien_q;
  logic [NFLG-1:0] arm_q;
  logic [31:0] cfg_q;
  logic [2:0] ctrl_q;
  logic [15:0] cmp_q;
  logic [15:0] arr_q;
  logic [15:0] cnt_q;
  logic arr_pend_q;
  logic cmp_pend_q;
  logic dir_q;
  logic dir_vld_q;
  logic irq_q;
  logic [31:0] rdata_q;
  lte_run_e run_q;
  lte_run_e run_d;

  // register decode
  wire logic wr_clr = wr_in && addr_in == OFS_CLR;
  wire logic wr_ien = wr_in && addr_in == OFS_IEN;
  wire logic wr_cfg = wr_in && addr_in == OFS_CFG;
  wire logic wr_ctrl = wr_in && addr_in == OFS_CTRL;
  wire logic wr_cmp = wr_in && addr_in == OFS_CMP;
  wire logic wr_arr = wr_in && addr_in == OFS_ARR;
  wire logic [NFLG-1:0] clr_v = wr_clr ? wdata_in[NFLG-1:0] : '0;

  // configuration fields
  wire logic [1:0] pol = cfg_q[CFG_POL_LO +: 2];
  wire logic [1:0] trg_sel = cfg_q[CFG_TRG_LO +: 2];
  wire logic tmo_en = cfg_q[CFG_TMO];
  wire logic int_clk = !cfg_q[CFG_CLOCK_SOURCE_SELECT];
  wire logic quad_mode = cfg_q[CFG_ENC] && int_clk;
  wire logic nq_mode = cfg_q[CFG_PULSE_DIRECTION_DECODER_ENABLE] && !cfg_q[CFG_ENC] && int_clk;
  wire logic dec_mode = quad_mode || nq_mode;
  wire logic en = ctrl_q[CTRL_EN];
  wire logic go = en && ctrl_q[CTRL_CONT];
  wire logic running = run_q == LTE_RUN;

  // filtered pin views
  wire logic r1 = pins.rise[PIN_IN1];
  wire logic f1 = pins.fall[PIN_IN1];
  wire logic r2 = pins.rise[PIN_IN2];
  wire logic f2 = pins.fall[PIN_IN2];
  wire logic l1 = pins.lvl[PIN_IN1];
  wire logic l2 = pins.lvl[PIN_IN2];
  wire logic use_r = pol != POL_FALL;
  wire logic use_f = pol != POL_RISE;

  // quadrature table; opposite line is stable at the active edge
  wire logic q_up = (use_r && r1 && !l2) || (use_f && f1 && l2) ||
                    (use_r && r2 && l1) || (use_f && f2 && !l1);
  wire logic q_dn = (use_r && r1 && l2) || (use_f && f1 && !l2) ||
                    (use_r && r2 && !l1) || (use_f && f2 && l1);
  // both-edge polarity simply enables both halves of the table

  // pulse-direction: both lines high is an illegal pattern and is ignored
  wire logic n_up = r1 && !l2;
  wire logic n_dn = r2 && !l1;

  // trigger detection
  wire logic trg_evt = (trg_sel == TRG_RISE) ? pins.rise[PIN_TRG] :
                       (trg_sel == TRG_FALL) ? pins.fall[PIN_TRG] :
                       (trg_sel == TRG_SW) ? 1'b0 :
                       (pins.rise[PIN_TRG] || pins.fall[PIN_TRG]);
  wire logic tmo_hit = running && trg_evt && tmo_en;
  wire logic trg_ok = (run_q == LTE_WAIT && go && trg_evt) || tmo_hit;

  // count steps
  wire logic step_up = running && !tmo_hit &&
                       (quad_mode ? q_up : nq_mode ? n_up : 1'b1);
  wire logic step_dn = running && !tmo_hit &&
                       (quad_mode ? q_dn : nq_mode ? n_dn : 1'b0);
  wire logic cnt_chg = tmo_hit || step_up || step_dn;

  // counter stays inside zero to reload, wrapping either way
  wire logic [15:0] cnt_inc = (cnt_q >= arr_q) ? 16'h0000 : cnt_q + 16'h0001;
  wire logic [15:0] cnt_dec = (cnt_q == 16'h0000 || cnt_q > arr_q) ? arr_q :
                              cnt_q - 16'h0001;
  wire logic [15:0] cnt_nx = !running ? CNT_RST :
                             tmo_hit ? 16'h0000 :
                             step_up ? cnt_inc :
                             step_dn ? cnt_dec : cnt_q;

  // direction change only counts in decoder modes
  wire logic dir_chg_up = dec_mode && step_up && (!dir_vld_q || !dir_q);
  wire logic dir_chg_dn = dec_mode && step_dn && (!dir_vld_q || dir_q);

  // events into status
  wire logic [NFLG-1:0] set_v;
  assign set_v[FLG_CMPM] = cnt_chg && cnt_nx == cmp_q;
  assign set_v[FLG_ARRM] = cnt_chg && cnt_nx == arr_q;
  assign set_v[FLG_EXTERNAL_TRIGGER_FLAG] = trg_ok;
  assign set_v[FLG_CMPUPD] = cmp_pend_q;
  assign set_v[FLG_RELOAD_WRITE_DONE_FLAG] = arr_pend_q;
  assign set_v[FLG_UP] = dir_chg_up;
  assign set_v[FLG_DOWN] = dir_chg_dn;

  // set wins over a same-cycle clear
  wire logic [NFLG-1:0] sts_d = (sts_q & ~clr_v) | set_v;
  wire logic [NFLG-1:0] ien_d = wr_ien ? wdata_in[NFLG-1:0] : ien_q;
  // arm only while enabled at set time, so stale flags stay quiet
  wire logic [NFLG-1:0] arm_d = ien_d & sts_d &
                                (arm_q | (set_v & ien_q));
  wire logic irq_d = |arm_d;

  // run sequencing
  always_comb begin
    run_d = run_q;
    unique case (run_q)
      LTE_IDLE: begin
        if (go) begin
          run_d = (trg_sel == TRG_SW) ? LTE_RUN : LTE_WAIT;
        end
      end
      LTE_WAIT: begin
        if (!go) begin
          run_d = LTE_IDLE;
        end else if (trg_evt) begin
          run_d = LTE_RUN;
        end
      end
      LTE_RUN: begin
        if (!go) begin
          run_d = LTE_IDLE;
        end
      end
    endcase
  end

  // read mux; clear register reads as zero
  wire logic [31:0] rd_mux =
    (addr_in == OFS_STS) ? {25'h0, sts_q} :
    (addr_in == OFS_IEN) ? {25'h0, ien_q} :
    (addr_in == OFS_CFG) ? cfg_q :
    (addr_in == OFS_CTRL) ? {29'h0, ctrl_q} :
    (addr_in == OFS_CMP) ? {16'h0, cmp_q} :
    (addr_in == OFS_ARR) ? {16'h0, arr_q} :
    (addr_in == OFS_CNT) ? {16'h0, cnt_q} : 32'h0000_0000;
  // mode bits leave the run state untouched until go drops
  wire logic [2:0] ctrl_d = wdata_in[CTRL_EN] ? wdata_in[2:0] : CTRL_RST;

  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      sts_q <= '0;
      ien_q <= '0;
      arm_q <= '0;
      irq_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
    end else if (ce_in) begin
      sts_q <= sts_d;
      ien_q <= ien_d;
      arm_q <= arm_d;
      irq_q <= irq_d;
      rdata_q <= rd_in ? rd_mux : 32'h0000_0000;
    end
  end

  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      cfg_q <= CFG_RST;
      ctrl_q <= CTRL_RST;
      cmp_q <= CMP_RST;
      arr_q <= ARR_RST;
      cmp_pend_q <= 1'b0;
      arr_pend_q <= 1'b0;
    end else if (ce_in) begin
      if (wr_cfg) cfg_q <= wdata_in & CFG_MASK;
      if (wr_ctrl) ctrl_q <= ctrl_d;
      if (wr_cmp) cmp_q <= wdata_in[15:0];
      if (wr_arr) arr_q <= wdata_in[15:0];
      cmp_pend_q <= wr_cmp;
      arr_pend_q <= wr_arr;
    end
  end

  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      run_q <= LTE_IDLE;
      cnt_q <= CNT_RST;
      dir_q <= 1'b1;
      dir_vld_q <= 1'b0;
    end else if (ce_in) begin
      run_q <= run_d;
      cnt_q <= cnt_nx;
      if (step_up || step_dn) dir_q <= step_up;
      dir_vld_q <= running && (dir_vld_q || step_up || step_dn);
    end
  end

  assign rdata_out = rdata_q;
  assign irq_out = irq_q;
  assign dir_up_out = dir_q;

  // checks
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!nrst_in);

  AST_RANGE: assert property (
    ce_in && cnt_chg && !wr_arr |=> cnt_q <= arr_q)
    else $error("counter left zero to reload range");
  AST_DIR_UP: assert property (
    ce_in && dec_mode && step_up && dir_vld_q && !dir_q && !clr_v[FLG_UP]
    |=> sts_q[FLG_UP] && dir_up_out)
    else $error("up flag missing after direction change");
  AST_QUAD_RISE: assert property (
    ce_in && quad_mode && running && pol == POL_RISE && r1 && l2 &&
    !tmo_hit && !wr_ctrl && cnt_q != 16'h0000 && cnt_q <= arr_q
    |=> cnt_q == $past(cnt_q) - 16'h0001)
    else $error("rising input 1 with input 2 high did not count down");
  AST_QUAD_FALL_IGN: assert property (
    ce_in && quad_mode && running && pol == POL_FALL && !f1 && !f2 &&
    !tmo_hit && !wr_ctrl |=> $stable(cnt_q))
    else $error("rising edge counted in falling polarity");
  AST_NQ_HOLD: assert property (
    ce_in && nq_mode && running && l1 && l2 && !tmo_hit && !wr_ctrl
    |=> $stable(cnt_q))
    else $error("counter moved while both inputs high");
  AST_TMO: assert property (
    ce_in && tmo_hit |=> cnt_q == 16'h0000 && sts_q[FLG_EXTERNAL_TRIGGER_FLAG])
    else $error("timeout trigger did not restart counter");
  AST_ARRM: assert property (
    ce_in && step_dn && dec_mode && cnt_q == 16'h0000 && arr_q != 16'h0000
    |=> sts_q[FLG_ARRM])
    else $error("reload match missed when counting down");
  AST_STALE: assert property (
    ce_in && arm_q == '0 && set_v == '0 |=> !irq_out)
    else $error("interrupt for a flag pending before enable");
  AST_IRQ: assert property (
    ce_in && |(set_v & ien_q) && !wr_ien |=> irq_out)
    else $error("enabled event did not raise interrupt");
  AST_CLR: assert property (
    ce_in && wr_clr && (set_v & wdata_in[NFLG-1:0]) == '0
    |=> (sts_q & $past(wdata_in[NFLG-1:0])) == '0)
    else $error("clear write left flag set");
  AST_DISCARD: assert property (
    ce_in && running && trg_evt && !tmo_en && !wr_clr
    |=> $stable(sts_q[FLG_EXTERNAL_TRIGGER_FLAG]))
    else $error("discarded trigger set the trigger flag");
  AST_WRDONE: assert property (
    ce_in && wr_arr ##1 ce_in |=> sts_q[FLG_RELOAD_WRITE_DONE_FLAG])
    else $error("reload write done flag missing");
  AST_QUAD_IN2: assert property (
    ce_in && quad_mode && running && pol == POL_RISE && r2 && l1 && !r1 &&
    !tmo_hit && cnt_q < arr_q |=> cnt_q == $past(cnt_q) + 16'h0001)
    else $error("rising input 2 with input 1 high did not count up");
  AST_QUAD_FALL: assert property (
    ce_in && quad_mode && running && pol == POL_FALL && f1 && l2 && !f2 &&
    !tmo_hit && cnt_q < arr_q |=> cnt_q == $past(cnt_q) + 16'h0001)
    else $error("falling input 1 with input 2 high did not count up");
  AST_QUAD_BOTH: assert property (
    ce_in && quad_mode && running && pol == POL_BOTH && f2 && l1 && !r1 &&
    !f1 && !tmo_hit && cnt_q != 16'h0000 && cnt_q <= arr_q
    |=> cnt_q == $past(cnt_q) - 16'h0001)
    else $error("falling input 2 with input 1 high did not count down");
  AST_NQ_UP: assert property (
    ce_in && nq_mode && running && r1 && !l2 && !tmo_hit && cnt_q < arr_q
    |=> cnt_q == $past(cnt_q) + 16'h0001)
    else $error("input 1 pulse did not count up");
  AST_CMPM: assert property (
    ce_in && running && !dec_mode && !tmo_hit && cnt_q < arr_q && !wr_cmp &&
    cnt_q + 16'h0001 == cmp_q |=> sts_q[FLG_CMPM] && cnt_q == cmp_q)
    else $error("compare match flag missing");
  AST_ARRM_UP: assert property (
    ce_in && step_up && cnt_q + 16'h0001 == arr_q |=> sts_q[FLG_ARRM])
    else $error("reload match flag missing when counting up");
  AST_EXTERNAL_TRIGGER_FLAG: assert property (
    ce_in && run_q == LTE_WAIT && go && trg_evt
    |=> sts_q[FLG_EXTERNAL_TRIGGER_FLAG] && running)
    else $error("start trigger did not set the trigger flag");
  AST_DIR_DN: assert property (
    ce_in && dec_mode && step_dn && !step_up && dir_vld_q && dir_q &&
    !clr_v[FLG_DOWN] |=> sts_q[FLG_DOWN] && !dir_up_out)
    else $error("down flag missing after direction change");

  COV_QUAD_DN: cover property (ce_in && quad_mode && step_dn);
  COV_NQ_UP: cover property (ce_in && nq_mode && step_up);
  COV_TMO: cover property (ce_in && tmo_hit);
  COV_IRQ: cover property (irq_out);
  COV_FREEZE: cover property (!ce_in && running);
endmodule // lte_timer

// ### sim/lte_enc_model.sv
// incremental encoder model driving the two decoder input lines
`timescale 1ns/1ns
module lte_enc_model (
  // clock
  input wire logic core_clk_in,
  // encoder lines
  output logic enc_a_out,
  output logic enc_b_out
);
  // lines change at most every seven clocks, well inside quarter rate
  localparam int GAP = 6;

  initial begin
    enc_a_out = 1'b0;
    enc_b_out = 1'b0;
  end

  task automatic move(input logic a, input logic b);
    @(posedge core_clk_in);
    enc_a_out <= a;
    enc_b_out <= b;
    repeat (GAP) @(posedge core_clk_in);
  endtask

  // gray position: bit1 is line b, bit0 is a xor b; only one line flips
  task automatic quad_step(input logic up);
    logic [1:0] p;
    p = {enc_b_out, enc_a_out ^ enc_b_out};
    p = up ? p + 2'h1 : p - 2'h1;
    move(p[0] ^ p[1], p[1]);
  endtask

  // pulse on line a means up, on line b means down
  task automatic pulse(input logic up);
    move(up, !up);
    move(1'b0, 1'b0);
  endtask

  // line b rises while a is still high
  task automatic both_high();
    move(1'b1, 1'b0);
    move(1'b1, 1'b1);
    move(1'b1, 1'b0);
    move(1'b0, 1'b0);
  endtask
endmodule // lte_enc_model

// ### sim/lte_timer_tb.sv
// self-checking bench for the low power timer encoder interface
`timescale 1ns/1ns
module lte_timer_tb import lte_pkg::*; ;
  logic core_clk, nrst, ce, wr, rd, trig;
  logic [ADDR_W-1:0] addr;
  logic [31:0] wdata, d, d2;
  wire logic [31:0] rdata;
  wire logic irq, dir_up, enc_a, enc_b;
  int errors, checked;
  logic [15:0] arr, cmp, exp_cnt;
  logic have_dir, last_up, a0, b0;
  logic [1:0] ev;

  lte_timer lte_timer_inst (.core_clk_in(core_clk), .nrst_in(nrst),
    .ce_in(ce), .addr_in(addr), .wdata_in(wdata), .wr_in(wr), .rd_in(rd),
    .rdata_out(rdata), .enc_a_in(enc_a), .enc_b_in(enc_b), .trig_in(trig),
    .irq_out(irq), .dir_up_out(dir_up));
  lte_enc_model lte_enc_model_inst (.core_clk_in(core_clk),
    .enc_a_out(enc_a), .enc_b_out(enc_b));

  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  task automatic give_verdict();
    if (errors == 0 && checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    checked++;
    if (g !== e) begin
      $display("ERROR %s expected %h seen %h", nm, e, g);
      errors++;
    end
  endtask

  task automatic reg_wr(input logic [4:0] a, input logic [31:0] v);
    @(posedge core_clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= v;
    @(posedge core_clk);
    wr <= 1'b0;
  endtask

  // data stand only in the cycle after the strobe
  task automatic reg_rd(input logic [4:0] a, output logic [31:0] v);
    @(posedge core_clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge core_clk);
    rd <= 1'b0;
    #1 v = rdata;
  endtask

  task automatic rdchk(input logic [4:0] a, input logic [31:0] e,
                       input string nm);
    logic [31:0] v;
    reg_rd(a, v);
    chk(nm, e, v);
  endtask

  task automatic do_reset();
    nrst <= 1'b0;
    repeat (20) @(posedge core_clk);
    nrst <= 1'b1;
    @(posedge core_clk);
  endtask

  function automatic logic [1:0] quad_eval(input logic [1:0] pol,
    input logic a0, input logic b0, input logic a1, input logic b1);
    logic ch, rise, oth, up, cnt;
    ch = a1 != a0;
    rise = ch ? a1 : b1;
    oth = ch ? b1 : a1;
    up = ch ? rise ^ oth : !(rise ^ oth);
    cnt = pol == POL_BOTH || (pol == POL_RISE && rise) ||
          (pol == POL_FALL && !rise);
    return {cnt, up};
  endfunction

  function automatic logic [15:0] next_cnt(input logic [15:0] c,
    input logic up, input logic [15:0] top);
    if (up) return (c == top) ? 16'h0000 : c + 16'h0001;
    return (c == 16'h0000) ? top : c - 16'h0001;
  endfunction

  // decoder run from clean lines; internal clock, no prescale
  task automatic setup(input logic [31:0] cfg);
    // one line at a time, the lines never switch together
    lte_enc_model_inst.move(1'b0, enc_b);
    lte_enc_model_inst.move(1'b0, 1'b0);
    do_reset();
    arr = 16'($urandom_range(8, 3));
    cmp = 16'($urandom_range(arr - 1, 0));
    reg_wr(OFS_ARR, {16'h0000, arr});
    reg_wr(OFS_CMP, {16'h0000, cmp});
    reg_wr(OFS_IEN, 32'h0000_0060);
    reg_wr(OFS_CFG, cfg);
    reg_wr(OFS_CTRL, 32'h0000_0001);
    reg_wr(OFS_CTRL, 32'h0000_0005);
    reg_wr(OFS_CLR, 32'h0000_007F);
    exp_cnt = 16'h0000;
    have_dir = 1'b0;
  endtask

  task automatic step_chk(input logic cnt, input logic up);
    logic [31:0] sts;
    sts = 32'h0000_0000;
    if (cnt) begin
      exp_cnt = next_cnt(exp_cnt, up, arr);
      if (!have_dir || up != last_up) sts[up ? FLG_UP : FLG_DOWN] = 1'b1;
      have_dir = 1'b1;
      last_up = up;
      sts[FLG_ARRM] = exp_cnt == arr;
      sts[FLG_CMPM] = exp_cnt == cmp;
    end
    rdchk(OFS_CNT, {16'h0000, exp_cnt}, "counter");
    rdchk(OFS_STS, sts, "status");
    chk("irq", {31'h0, sts[FLG_UP] | sts[FLG_DOWN]}, {31'h0, irq});
    if (have_dir) chk("dir", {31'h0, last_up}, {31'h0, dir_up});
    reg_wr(OFS_CLR, 32'h0000_007F);
  endtask

  task automatic trig_pulse();
    @(posedge core_clk);
    trig <= 1'b1;
    repeat (6) @(posedge core_clk);
    trig <= 1'b0;
    repeat (6) @(posedge core_clk);
  endtask

  task automatic trig_setup(input logic [31:0] cfg);
    do_reset();
    reg_wr(OFS_ARR, 32'h0000_0FFF);
    reg_wr(OFS_CMP, 32'h0000_0028);
    reg_wr(OFS_CFG, cfg | ({30'h0, TRG_RISE} << CFG_TRG_LO));
    reg_wr(OFS_CTRL, 32'h0000_0001);
    reg_wr(OFS_CTRL, 32'h0000_0005);
    trig_pulse();
  endtask

  initial begin
    repeat (20000) @(posedge core_clk);
    errors++;
    give_verdict();
  end

  initial begin
    nrst = 1'b0; ce = 1'b1; wr = 1'b0; rd = 1'b0; trig = 1'b0;
    addr = '0; wdata = 32'h0000_0000; errors = 0; checked = 0;
    void'($urandom(87583));
    do_reset();
    rdchk(OFS_ARR, {16'h0000, ARR_RST}, "reload reset");
    rdchk(OFS_CMP, {16'h0000, CMP_RST}, "compare reset");
    rdchk(OFS_STS, 32'h0000_0000, "status reset");
    rdchk(5'h1E, 32'h0000_0000, "unmapped");
    chk("dir reset", 32'h1, {31'h0, dir_up});
    reg_wr(OFS_CMP, 32'h0000_0003);
    rdchk(OFS_STS, 32'h0000_0008, "cmp done");
    reg_wr(OFS_IEN, 32'h0000_0008);
    repeat (2) @(posedge core_clk);
    chk("irq pending", 32'h0, {31'h0, irq});
    reg_wr(OFS_CLR, 32'h0000_0000);
    rdchk(OFS_STS, 32'h0000_0008, "clear zero");
    reg_wr(OFS_CLR, 32'h0000_0008);
    reg_wr(OFS_ARR, 32'h0000_0009);
    rdchk(OFS_STS, 32'h0000_0010, "arr done");
    reg_wr(OFS_CMP, 32'h0000_0004);
    repeat (2) @(posedge core_clk);
    chk("irq set", 32'h1, {31'h0, irq});
    reg_wr(OFS_IEN, 32'h0000_0000);
    repeat (2) @(posedge core_clk);
    chk("irq off", 32'h0, {31'h0, irq});
    for (int i = 0; i < 3; i++) begin
      setup((32'h1 << CFG_ENC) | (32'(i) << CFG_POL_LO));
      repeat (12) begin
        a0 = enc_a;
        b0 = enc_b;
        lte_enc_model_inst.quad_step(1'($urandom_range(1, 0)));
        ev = quad_eval(2'(i), a0, b0, enc_a, enc_b);
        step_chk(ev[1], ev[0]);
      end
    end
    setup(32'h1 << CFG_PULSE_DIRECTION_DECODER_ENABLE);
    repeat (12) begin
      ev[0] = 1'($urandom_range(1, 0));
      lte_enc_model_inst.pulse(ev[0]);
      step_chk(1'b1, ev[0]);
    end
    lte_enc_model_inst.both_high();
    step_chk(1'b1, 1'b1);
    trig_setup(32'h0000_0000);
    reg_rd(OFS_STS, d);
    chk("trig flag", 32'h1, {31'h0, d[FLG_EXTERNAL_TRIGGER_FLAG]});
    reg_wr(OFS_CLR, 32'h0000_007F);
    trig_pulse();
    reg_rd(OFS_STS, d);
    chk("late trig", 32'h0, {31'h0, d[FLG_EXTERNAL_TRIGGER_FLAG]});
    trig_setup((32'h1 << CFG_TMO) | (32'h2 << CFG_TRG_LO));
    repeat (10) @(posedge core_clk);
    reg_wr(OFS_CLR, 32'h0000_007F);
    trig_pulse();
    reg_rd(OFS_CNT, d);
    chk("restart", 32'h1, {31'h0, d < 32'h0000_0010});
    reg_rd(OFS_STS, d);
    chk("no match", 32'h0, {31'h0, d[FLG_CMPM]});
    repeat (50) @(posedge core_clk);
    reg_rd(OFS_STS, d);
    chk("timeout", 32'h1, {31'h0, d[FLG_CMPM]});
    // counter moves on the three enabled edges only
    reg_rd(OFS_CNT, d);
    @(posedge core_clk);
    ce <= 1'b0;
    repeat (20) @(posedge core_clk);
    ce <= 1'b1;
    reg_rd(OFS_CNT, d2);
    chk("freeze", d + 32'h0000_0003, d2);
    give_verdict();
  end
endmodule // lte_timer_tb
